// File: shared/e1_ctrl_pkg.sv
// constants for the e1 framer transmit/receive control block
package e1_ctrl_pkg;
	// register offsets
	localparam logic [7:0] ADDR_TRANSMIT_CONTROL   = 8'h11;
	localparam logic [7:0] ADDR_COMMON_CONTROL_ONE = 8'h12;
	// reset values (power-up contents unspecified; zero chosen)
	localparam logic [7:0] RST_TRANSMIT_CONTROL    = 8'h00;
	localparam logic [7:0] RST_COMMON_CONTROL_ONE  = 8'h00;
	// transmit_control fields
	localparam int TC_INTERNAL_SYNC_SELECT  = 7;
	localparam int TC_TS0_PASS_THROUGH      = 6;
	localparam int TC_AUTO_EBIT_ENABLE      = 5;
	localparam int TC_TX_UNFRAMED_ALL_ONES  = 4;
	localparam int TC_INTL_BIT_SOURCE       = 3;
	localparam int TC_TX_SIGNALLING_ALL_ONE = 2;
	localparam int TC_TX_SYNC_MODE          = 1;
	localparam int TC_TX_SYNC_DIRECTION     = 0;
	// common_control_one fields
	localparam int CC_FRAMER_LOOPBACK       = 7;
	localparam int CC_TX_LINE_CODE_ENABLE   = 6;
	localparam int CC_INSERT_BIT_ERROR      = 5;
	localparam int CC_TX_CHECKSUM_ENABLE    = 4;
	localparam int CC_RX_SIGNALLING_MODE    = 3;
	localparam int CC_RX_LINE_CODE_ENABLE   = 2;
	localparam int CC_PER_CHANNEL_LOOP_MODE = 1;
	localparam int CC_RX_CHECKSUM_ENABLE    = 0;
	// e1 frame geometry: 32 slots of 8 bits
	localparam int          FRAME_BITS      = 256;
	localparam logic [4:0]  SLOT_TS0        = 5'h00;
	localparam logic [4:0]  SLOT_TS16       = 5'h10;
	localparam logic [2:0]  BIT_SI          = 3'h0;
	localparam logic [2:0]  BIT_EBIT        = 3'h0;
	// transmit data fifo
	localparam int          FIFO_WIDTH      = 1;
	localparam int          FIFO_DEPTH      = 4;
endpackage

// File: core/e1_framer_tx_rx_control.sv
// e1 framer transmit/receive control registers and transmit data path
`timescale 1ns/1ps

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module e1_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	input  wire logic             clock_in,
	input  wire logic             sys_rst_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	input  wire logic             wr_valid_in,
	output logic                  wr_ready_out,
	output logic      [WIDTH-1:0] rd_data_out,
	output logic                  rd_valid_out,
	input  wire logic             rd_ready_in
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	wire              push = wr_valid_in && wr_ready_out;
	wire              pop  = rd_valid_out && rd_ready_in;
	wire [AW-1:0]     last = AW'(DEPTH - 1);

	assign wr_ready_out = count_reg != (AW+1)'(DEPTH);
	assign rd_valid_out = count_reg != '0;
	assign rd_data_out  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == last) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == last) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (push)
			mem_reg[wr_ptr_reg] <= wr_data_in;
	end
endmodule

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module e1_framer_tx_rx_control (
	input  wire logic       clock_in,
	input  wire logic       sys_rst_in,
	// host register port
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	// backplane serial data and sync
	input  wire logic       tx_serial_input_in,
	input  wire logic       tx_serial_valid_in,
	output logic            tx_serial_ready_out,
	input  wire logic       tx_sync_pin_in,
	output logic            tx_sync_pin_out,
	output logic            tx_sync_pin_oe_out,
	// recovered receive timing
	input  wire logic       rx_frame_sync_in,
	input  wire logic       rx_multiframe_sync_in,
	// alignment register bits from the framer
	input  wire logic       align_bit_in,
	input  wire logic       ebit_auto_in,
	// line side
	output logic            tx_line_data_out,
	output logic            tx_line_valid_out,
	input  wire logic       tx_line_ready_in,
	// control levels to the rest of the framer
	output logic            tx_frame_sync_out,
	output logic            tx_sync_multiframe_out,
	output logic            framer_loopback_out,
	output logic            per_channel_local_out,
	output logic            cas_search_enable_out,
	output logic            tx_hdb3_enable_out,
	output logic            rx_hdb3_enable_out,
	output logic            tx_crc4_enable_out,
	output logic            rx_crc4_enable_out
);
	// ------------------------------------------------------------
	// integration notes
	// ------------------------------------------------------------
	// register contents are unknown on the real part at power-up;
	// here they clear to zero, so software must still write both
	// registers before relying on any mode.
	// control outputs lag a register write by one clock, which keeps
	// every control level that leaves the block glitch free.
	// the bit counter only advances on accepted bits, so a slow
	// backplane stretches the frame instead of slipping it.
	// the line side sees one fifo of depth four; a stall longer than
	// that pushes back on the backplane through the ready output.
	// si and pass-through are not cross-checked in hardware: the host
	// keeps pass-through clear while si is taken internally.

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] transmit_control_reg;
	logic [7:0] common_control_one_reg;
	logic [7:0] rdata_reg;

	wire sel_tc = reg_addr_in == e1_ctrl_pkg::ADDR_TRANSMIT_CONTROL;
	wire sel_cc = reg_addr_in == e1_ctrl_pkg::ADDR_COMMON_CONTROL_ONE;
	wire [7:0] rd_mux = sel_tc ? transmit_control_reg :
		sel_cc ? common_control_one_reg : 8'h00;

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			transmit_control_reg   <= e1_ctrl_pkg::RST_TRANSMIT_CONTROL;
			common_control_one_reg <= e1_ctrl_pkg::RST_COMMON_CONTROL_ONE;
			rdata_reg              <= 8'h00;
		end else begin
			if (reg_wr_in && sel_tc)
				transmit_control_reg <= reg_wdata_in;
			if (reg_wr_in && sel_cc)
				common_control_one_reg <= reg_wdata_in;
			if (reg_rd_in)
				rdata_reg <= rd_mux;
		end
	end
	assign reg_rdata_out = rdata_reg;

	wire int_sync  = transmit_control_reg[e1_ctrl_pkg::TC_INTERNAL_SYNC_SELECT];
	wire pass_ts0  = transmit_control_reg[e1_ctrl_pkg::TC_TS0_PASS_THROUGH];
	wire auto_ebit = transmit_control_reg[e1_ctrl_pkg::TC_AUTO_EBIT_ENABLE];
	wire unf_ones  = transmit_control_reg[e1_ctrl_pkg::TC_TX_UNFRAMED_ALL_ONES];
	wire si_int    = transmit_control_reg[e1_ctrl_pkg::TC_INTL_BIT_SOURCE];
	wire ts16_ones = transmit_control_reg[e1_ctrl_pkg::TC_TX_SIGNALLING_ALL_ONE];
	wire sync_mf   = transmit_control_reg[e1_ctrl_pkg::TC_TX_SYNC_MODE];
	wire sync_out  = transmit_control_reg[e1_ctrl_pkg::TC_TX_SYNC_DIRECTION];
	wire ins_err   = common_control_one_reg[e1_ctrl_pkg::CC_INSERT_BIT_ERROR];

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] sync_pin_sr_reg;
	logic       sync_pin_last_reg;
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sync_pin_sr_reg   <= 2'h0;
			sync_pin_last_reg <= 1'b0;
		end else begin
			sync_pin_sr_reg   <= {sync_pin_sr_reg[0], tx_sync_pin_in};
			sync_pin_last_reg <= sync_pin_sr_reg[1];
		end
	end
	wire pin_rise = sync_pin_sr_reg[1] && !sync_pin_last_reg;

	// ------------------------------------------------------------
	// sync selection
	// ------------------------------------------------------------
	// internal receive sync
	wire frame_sync_src = (int_sync && !sync_out) ? rx_frame_sync_in : pin_rise;
	wire frame_sync_sel = sync_out ? 1'b0 : frame_sync_src;

	// ------------------------------------------------------------
	// transmit bit counter
	// ------------------------------------------------------------
	logic [7:0] bit_cnt_reg;
	wire        bit_step = tx_serial_valid_in && tx_serial_ready_out;
	wire [4:0]  slot     = bit_cnt_reg[7:3];
	wire [2:0]  bit_in   = bit_cnt_reg[2:0];
	wire        in_ts0   = slot == e1_ctrl_pkg::SLOT_TS0;
	wire        in_ts16  = slot == e1_ctrl_pkg::SLOT_TS16;

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			bit_cnt_reg <= 8'h00;
		else if (frame_sync_sel)
			bit_cnt_reg <= 8'h00;
		else if (bit_step)
			bit_cnt_reg <= bit_cnt_reg + 8'h01;
	end

	// ------------------------------------------------------------
	// time slot zero position decode
	// ------------------------------------------------------------
	// shared by the si and e-bit selects, so both see one slot map
	function automatic logic ts0_pos(input logic [4:0] s, input logic [2:0] b,
		input logic [2:0] pos);
		return (s == e1_ctrl_pkg::SLOT_TS0) && (b == pos);
	endfunction

	// ------------------------------------------------------------
	// bit error insertion
	// ------------------------------------------------------------
	// the error rides on the first bit accepted after the arm pulse;
	// a stalled backplane simply delays it, it is never lost
	logic ins_err_last_reg;
	logic err_pending_reg;
	wire  err_arm  = ins_err && !ins_err_last_reg;
	wire  err_used = err_pending_reg && bit_step;
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ins_err_last_reg <= 1'b0;
			err_pending_reg  <= 1'b0;
		end else begin
			ins_err_last_reg <= ins_err;
			err_pending_reg  <= err_arm | (err_pending_reg & !err_used);
		end
	end

	// ------------------------------------------------------------
	// transmit bit selection
	// ------------------------------------------------------------
	// si bit source
	wire si_bit   = ts0_pos(slot, bit_in, e1_ctrl_pkg::BIT_SI);
	wire si_value = si_int ? align_bit_in : tx_serial_input_in;
	// ts0 from registers or serial input
	wire ts0_val  = pass_ts0 ? tx_serial_input_in : align_bit_in;
	wire ebit_pos = auto_ebit && ts0_pos(slot, bit_in, e1_ctrl_pkg::BIT_EBIT);
	// e-bit wins over si: the e-bit shares the si position, so
	// giving si priority would leave the auto enable with no effect
	wire ts0_bit  = ebit_pos ? ebit_auto_in : (si_bit ? si_value : ts0_val);

	// ------------------------------------------------------------
	// slot merge
	// ------------------------------------------------------------
	// slot zero gets its own source, slot sixteen can be forced to ones, every other slot passes through
	wire framed   = in_ts0 ? ts0_bit : tx_serial_input_in;
	wire sig_bit  = (ts16_ones && in_ts16) ? 1'b1 : framed;

	// ------------------------------------------------------------
	// whole-frame overrides
	// ------------------------------------------------------------
	// unframed all ones
	// all ones also covers slot zero, so the far end loses alignment
	wire pre_err  = unf_ones ? 1'b1 : sig_bit;
	// error applied last so it shows even on an all-ones stream
	wire tx_bit   = pre_err ^ err_pending_reg;

	// ------------------------------------------------------------
	// line fifo
	// ------------------------------------------------------------
	logic fifo_data;
	logic fifo_valid;
	e1_fifo #(
		.WIDTH(e1_ctrl_pkg::FIFO_WIDTH),
		.DEPTH(e1_ctrl_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock_in    (clock_in),
		.sys_rst_in  (sys_rst_in),
		.wr_data_in  (tx_bit),
		.wr_valid_in (tx_serial_valid_in),
		.wr_ready_out(tx_serial_ready_out),
		.rd_data_out (fifo_data),
		.rd_valid_out(fifo_valid),
		.rd_ready_in (tx_line_ready_in)
	);
	assign tx_line_data_out  = fifo_data;
	assign tx_line_valid_out = fifo_valid;

	// ------------------------------------------------------------
	// registered control outputs
	// ------------------------------------------------------------
	logic [10:0] ctl_reg;
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ctl_reg <= 11'h000;
		end else begin
			ctl_reg[0]  <= int_sync ? rx_multiframe_sync_in : rx_frame_sync_in;
			ctl_reg[1]  <= sync_out;
			ctl_reg[2]  <= frame_sync_sel;
			ctl_reg[3]  <= sync_mf;
			ctl_reg[4]  <= common_control_one_reg[e1_ctrl_pkg::CC_FRAMER_LOOPBACK];
			ctl_reg[5]  <= common_control_one_reg[e1_ctrl_pkg::CC_PER_CHANNEL_LOOP_MODE];
			ctl_reg[6]  <= !common_control_one_reg[e1_ctrl_pkg::CC_RX_SIGNALLING_MODE];
			ctl_reg[7]  <= common_control_one_reg[e1_ctrl_pkg::CC_TX_LINE_CODE_ENABLE];
			ctl_reg[8]  <= common_control_one_reg[e1_ctrl_pkg::CC_RX_LINE_CODE_ENABLE];
			ctl_reg[9]  <= common_control_one_reg[e1_ctrl_pkg::CC_TX_CHECKSUM_ENABLE];
			ctl_reg[10] <= common_control_one_reg[e1_ctrl_pkg::CC_RX_CHECKSUM_ENABLE];
		end
	end
	// is host-side; the mux still lets si_int override the si bit
	assign tx_sync_pin_out        = ctl_reg[0];
	assign tx_sync_pin_oe_out     = ctl_reg[1];
	assign tx_frame_sync_out      = ctl_reg[2];
	assign tx_sync_multiframe_out = ctl_reg[3];
	assign framer_loopback_out    = ctl_reg[4];
	assign per_channel_local_out  = ctl_reg[5];
	assign cas_search_enable_out  = ctl_reg[6];
	assign tx_hdb3_enable_out     = ctl_reg[7];
	assign rx_hdb3_enable_out     = ctl_reg[8];
	assign tx_crc4_enable_out     = ctl_reg[9];
	assign rx_crc4_enable_out     = ctl_reg[10];
endmodule

// File: sim/e1_framer_tx_rx_control_properties.sv
// assertion checker for the e1 framer control block
`timescale 1ns/1ps
module e1_ctrl_props (
	input wire logic       clock_in,
	input wire logic       sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       reg_wr_in,
	input wire logic       reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic       rx_frame_sync_in,
	input wire logic       rx_multiframe_sync_in,
	input wire logic       tx_line_data_out,
	input wire logic       tx_line_valid_out,
	input wire logic       tx_line_ready_in,
	input wire logic       tx_frame_sync_out,
	input wire logic       tx_sync_pin_out,
	input wire logic       tx_sync_pin_oe_out,
	input wire logic       tx_sync_multiframe_out,
	input wire logic       framer_loopback_out,
	input wire logic       per_channel_local_out,
	input wire logic       cas_search_enable_out,
	input wire logic       tx_hdb3_enable_out,
	input wire logic       rx_hdb3_enable_out,
	input wire logic       tx_crc4_enable_out,
	input wire logic       rx_crc4_enable_out
);
	logic [7:0] tc_shadow_reg;
	default clocking dc @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	sequence cc_wr;
		reg_wr_in && reg_addr_in == 8'h12;
	endsequence
	sequence tc_wr;
		reg_wr_in && reg_addr_in == 8'h11;
	endsequence
	// shadow of the transmit control register, for the sync selection checks
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			tc_shadow_reg <= 8'h00;
		else if (reg_wr_in && reg_addr_in == 8'h11)
			tc_shadow_reg <= reg_wdata_in;
	end
	loopback_follow_a: assert property (
		cc_wr |-> ##2 framer_loopback_out == $past(reg_wdata_in[7], 2)) else $error("loopback bad");
	cas_search_a: assert property (
		cc_wr |-> ##2 cas_search_enable_out == !$past(reg_wdata_in[3], 2)) else $error("cas bad");
	chan_loop_a: assert property (
		cc_wr |-> ##2 per_channel_local_out == $past(reg_wdata_in[1], 2)) else $error("pcl bad");
	line_code_a: assert property (
		cc_wr |-> ##2 tx_hdb3_enable_out == $past(reg_wdata_in[6], 2)
		&& rx_hdb3_enable_out == $past(reg_wdata_in[2], 2)) else $error("hdb3 bad");
	checksum_en_a: assert property (
		cc_wr |-> ##2 tx_crc4_enable_out == $past(reg_wdata_in[4], 2)
		&& rx_crc4_enable_out == $past(reg_wdata_in[0], 2)) else $error("crc4 bad");
	sync_mode_dir_a: assert property (
		tc_wr |-> ##2 {tx_sync_multiframe_out, tx_sync_pin_oe_out} == $past(reg_wdata_in[1:0], 2))
		else $error("sync cfg bad");
	sync_pin_drive_a: assert property (
		!$past(sys_rst_in) |-> tx_sync_pin_out == $past(tc_shadow_reg[7] ?
		rx_multiframe_sync_in : rx_frame_sync_in)) else $error("sync pin bad");
	internal_sync_a: assert property (
		!$past(sys_rst_in) && $past(tc_shadow_reg[7] && !tc_shadow_reg[0]) |->
		tx_frame_sync_out == $past(rx_frame_sync_in)) else $error("frame sync bad");
	line_hold_a: assert property (
		tx_line_valid_out && !tx_line_ready_in |=> tx_line_valid_out && $stable(tx_line_data_out))
		else $error("line data dropped");
	unmapped_read_a: assert property (
		reg_rd_in && reg_addr_in == 8'h13 |=> reg_rdata_out == 8'h00) else $error("unmapped read");
endmodule
bind e1_framer_tx_rx_control e1_ctrl_props e1_ctrl_props_inst (.*);

// File: sim/backplane_model.sv
// backplane serial source feeding the transmit data path
`timescale 1ns/1ps
module backplane_model (
	input  wire logic       clock_in,
	input  wire logic       sys_rst_in,
	input  wire logic       load_in,
	input  wire logic [8:0] budget_in,
	input  wire logic       ready_in,
	output logic            data_out,
	output logic            valid_out
);
	logic [7:0] idx_reg;
	logic [8:0] rem_reg;
	logic       last_reg;
	assign valid_out = rem_reg != 9'h000;
	// idle line shows the inverse of the last bit, never a stale copy
	assign data_out  = valid_out ? idx_reg[0] ^ idx_reg[4] : ~last_reg;
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			idx_reg  <= 8'h00;
			rem_reg  <= 9'h000;
			last_reg <= 1'b0;
		end else if (load_in) begin
			rem_reg <= budget_in;
		end else if (valid_out && ready_in) begin
			idx_reg  <= idx_reg + 8'h01;
			rem_reg  <= rem_reg - 9'h001;
			last_reg <= data_out;
		end
	end
endmodule

// File: sim/e1_framer_tx_rx_control_tb.sv
// self-checking bench for the e1 framer control block
`timescale 1ns/1ps
module e1_framer_tx_rx_control_tb;
	logic clock_in, sys_rst_in, reg_wr_in, reg_rd_in, tx_serial_input_in, tx_serial_valid_in;
	logic tx_serial_ready_out, tx_sync_pin_in, tx_sync_pin_out, tx_sync_pin_oe_out, load;
	logic rx_frame_sync_in, rx_multiframe_sync_in, align_bit_in, ebit_auto_in;
	logic tx_line_data_out, tx_line_valid_out, tx_line_ready_in, tx_frame_sync_out;
	logic tx_sync_multiframe_out, framer_loopback_out, per_channel_local_out, cas_search_enable_out;
	logic tx_hdb3_enable_out, rx_hdb3_enable_out, tx_crc4_enable_out, rx_crc4_enable_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, k, rv;
	logic [8:0] budget;
	int         fails, samples_checked, cyc;
	localparam logic [7:0] SCFG [4] = '{8'h02, 8'h01, 8'h80, 8'h81};
	localparam logic [7:0] TCFG [6] = '{8'h00, 8'h08, 8'h40, 8'h04, 8'h10, 8'h20};
	e1_framer_tx_rx_control e1_framer_tx_rx_control_inst (.*);
	backplane_model backplane_model_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.load_in(load), .budget_in(budget), .ready_in(tx_serial_ready_out),
		.data_out(tx_serial_input_in), .valid_out(tx_serial_valid_in));
	// --------
	// tasks
	// --------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_in);
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		reg_wr_in    <= 1'b1;
		@(posedge clock_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_in);
		reg_addr_in <= a;
		reg_rd_in   <= 1'b1;
		@(posedge clock_in);
		reg_rd_in <= 1'b0;
		@(negedge clock_in);
		d = reg_rdata_out;
	endtask
	// align bit held high: ts0 bits not from serial read as ones
	function automatic logic expb(input logic [7:0] p, input logic [7:0] tc);
		logic s;
		s = p[0] ^ p[4];
		if (p[7:3] == 5'h00 && p[2:0] == 3'h0)
			s = tc[3] ? 1'b1 : s;
		else if (p[7:3] == 5'h00)
			s = tc[6] ? s : 1'b1;
		// auto e-bit input held low, so the e-bit reads as zero
		if (p[7:3] == 5'h00 && p[2:0] == 3'h0 && tc[5])
			s = 1'b0;
		if ((p[7:3] == 5'h10 && tc[2]) || tc[4])
			s = 1'b1;
		return s;
	endfunction
	task automatic regs_scn();
		rd(8'h11, rv);
		chk("tc reset", 8'h00, rv);
		rd(8'h12, rv);
		chk("cc reset", 8'h00, rv);
		wr(8'h11, 8'h36);
		wr(8'h12, 8'h9b);
		wr(8'h13, 8'hff);
		rd(8'h11, rv);
		chk("tc back", 8'h36, rv);
		rd(8'h12, rv);
		chk("cc back", 8'h9b, rv);
		rd(8'h13, rv);
		chk("unmapped", 8'h00, rv);
	endtask
	task automatic ctl_scn();
		logic [7:0] c;
		logic [7:0] g;
		for (int i = 0; i < 8; i++) begin
			c = 8'h01 << i;
			if (i == 5)
				continue;
			wr(8'h12, c);
			repeat (2) @(posedge clock_in);
			@(negedge clock_in);
			g = {1'b0, framer_loopback_out, per_channel_local_out, cas_search_enable_out,
				tx_hdb3_enable_out, rx_hdb3_enable_out, tx_crc4_enable_out, rx_crc4_enable_out};
			chk("ctl", {1'b0, c[7], c[1], ~c[3], c[6], c[2], c[4], c[0]}, g);
		end
		wr(8'h12, 8'h00);
	endtask
	task automatic sync_scn();
		foreach (SCFG[i]) begin
			wr(8'h11, SCFG[i]);
			repeat (30) @(posedge clock_in);
			@(negedge clock_in);
			chk("sync", {6'h00, SCFG[i][1:0]}, {6'h00, tx_sync_multiframe_out, tx_sync_pin_oe_out});
		end
		wr(8'h11, 8'h00);
	endtask
	task automatic stream(input logic [7:0] tc, input int n, input logic err);
		int got;
		int w;
		wr(8'h11, tc);
		@(posedge clock_in);
		tx_line_ready_in <= 1'b0;
		budget           <= n[8:0];
		load             <= 1'b1;
		@(posedge clock_in);
		load <= 1'b0;
		w = 0;
		// line side stalls until the fifo refuses
		do begin
			@(negedge clock_in);
			w++;
		end while (tx_serial_ready_out !== 1'b0 && w < 20);
		chk("fifo full", 8'h00, {7'h00, tx_serial_ready_out});
		@(posedge clock_in);
		tx_line_ready_in <= 1'b1;
		got = 0;
		while (got < n && w < 2000) begin
			@(negedge clock_in);
			w++;
			if (tx_line_valid_out === 1'b1) begin
				chk("line bit", {7'h00, expb(k, tc) ^ (err && got == 0)}, {7'h00, tx_line_data_out});
				k++;
				got++;
			end
		end
		if (got < n || w >= 2000)
			close_out();
	endtask
	task automatic err_scn();
		wr(8'h12, 8'h20);
		stream(8'h00, 8, 1'b1);
		wr(8'h12, 8'h20);
		stream(8'h00, 8, 1'b0);
		wr(8'h12, 8'h00);
	endtask
	// --------
	// clock, timing pulses and main sequence
	// --------
	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	always @(posedge clock_in) begin
		cyc                   <= cyc + 1;
		rx_frame_sync_in      <= (cyc % 7 == 0);
		rx_multiframe_sync_in <= (cyc % 23 == 0);
	end
	initial begin
		{reg_wr_in, reg_rd_in, tx_sync_pin_in, ebit_auto_in, load, tx_line_ready_in} = 6'h00;
		{rx_frame_sync_in, rx_multiframe_sync_in, align_bit_in} = 3'h1;
		{reg_addr_in, reg_wdata_in, k, budget} = 33'h0;
		{fails, samples_checked, cyc} = '0;
		sys_rst_in = 1'b1;
		repeat (4) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		regs_scn();
		ctl_scn();
		sync_scn();
		// si taken internally only while pass-through stays clear
		foreach (TCFG[i]) stream(TCFG[i], 256, 1'b0);
		err_scn();
		close_out();
	end
endmodule
